// ### dpw_pkg.sv
package dpw_pkg;

   // Wiper code width and frame geometry
   localparam int WIPER_W       = 10;
   localparam int RDATA_W       = 9;
   localparam int CNT_W         = 5;
   localparam int ADDR_CMD_BITS = 6;
   localparam int ERR_BIT_POS   = 6;
   localparam int CMD_BITS      = 8;
   localparam int FRAME16_BITS  = 16;

   // Memory addresses carried in the command byte
   localparam logic [3:0] ADDR_WIPER0 = 4'h0;
   localparam logic [3:0] ADDR_WIPER1 = 4'h1;
   localparam logic [3:0] ADDR_TERMINAL_CONTROL_REG   = 4'h4;

   // Terminal control register field positions, per network stride
   localparam int TC_B      = 0;
   localparam int TC_W      = 1;
   localparam int TC_A      = 2;
   localparam int TC_HW     = 3;
   localparam int TC_STRIDE = 4;
   localparam logic [7:0] TERMINAL_CONTROL_REG_RESET = 8'h77;
   localparam logic       TERMINAL_CONTROL_REG_RD_D8 = 1'b1;

   // Command encodings of the two command bits
   typedef enum logic [1:0] {
      DPW_CMD_WRITE = 2'h0,
      DPW_CMD_INC   = 2'h1,
      DPW_CMD_DEC   = 2'h2,
      DPW_CMD_READ  = 2'h3
   } dpw_cmd_t;

   typedef logic [WIPER_W-1:0] dpw_wiper_t;

   // Terminal switch state of one network
   typedef struct packed {
      logic a_conn;
      logic w_conn;
      logic b_conn;
      logic w_to_b;
   } dpw_term_t;

   // Pin group passing through the synchroniser
   typedef struct packed {
      logic cs_n;
      logic sck;
      logic sdi;
      logic sio;
      logic shutdown_pin_n_n;
   } dpw_pins_t;

   // Idle pin levels used as synchroniser reset value
   localparam dpw_pins_t PINS_IDLE = 5'h1B;

   // Whole state of the core
   typedef struct packed {
      logic                     mode11;
      logic                     cs_act;
      logic                     sck_prev;
      logic [CNT_W-1:0]         cnt;
      logic [WIPER_W-1:0]       sh;
      logic [3:0]               addr;
      dpw_cmd_t                 cmd;
      logic                     cmd_err;
      logic                     is_read;
      logic [RDATA_W-1:0]       rdata;
      logic                     sdo;
      logic                     sio_drv;
      logic                     sio_oe;
      dpw_wiper_t [1:0]         wiper;
      logic [7:0]               terminal_control_reg;
      dpw_wiper_t [1:0]         pos;
      dpw_term_t [1:0]          term;
   } dpw_state_t;

endpackage : dpw_pkg

// ### dpw_sync3.sv
`timescale 1ns/100ps
module dpw_sync3 #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         i_ref_clk,
   input  wire logic         i_reset,
   // Asynchronous input and filtered result
   input  wire logic [W-1:0] i_async,
   output logic [W-1:0]      o_stable
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] hold;
   } dpw_sync_st_t;

   dpw_sync_st_t st_q;
   dpw_sync_st_t st_d;

   // Three stages; a bit changes once stages two and three agree
   always_comb begin
      st_d      = st_q;
      st_d.s1   = i_async;
      st_d.s2   = st_q.s1;
      st_d.s3   = st_q.s2;
      st_d.hold = (st_q.s2 & st_q.s3) | (st_q.hold & (st_q.s2 ^ st_q.s3));
   end

   // State register
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         st_q <= {4{RST_VAL}};
      end else begin
         st_q <= st_d;
      end
   end

   assign o_stable = st_q.hold;

endmodule : dpw_sync3

// ### dpw_wiper_step.sv
`timescale 1ns/100ps
module dpw_wiper_step #(
   parameter int RES_BITS = 8
) (
   // Stored value and step requests
   input  wire dpw_pkg::dpw_wiper_t i_value,
   input  wire logic                i_inc,
   input  wire logic                i_dec,
   // Next stored value and effective tap
   output dpw_pkg::dpw_wiper_t      o_next,
   output dpw_pkg::dpw_wiper_t      o_pos
);
   import dpw_pkg::*;

   localparam dpw_wiper_t FULL_C = dpw_wiper_t'(1 << RES_BITS);
   localparam dpw_wiper_t ONE_C  = 10'h001;

   // Step with ignore cases and full-scale clamp
   always_comb begin
      o_next = i_value;
      if (i_inc && (i_value < FULL_C)) begin // RULE24 RULE26 RULE1
         o_next = i_value + ONE_C;
      end else if (i_dec && (i_value != '0) && (i_value <= FULL_C)) begin // RULE24 RULE26 RULE1
         o_next = i_value - ONE_C;
      end
      o_pos = (i_value > FULL_C) ? FULL_C : i_value; // RULE1
   end

endmodule : dpw_wiper_step

// ### dpw_digipot_core.sv
`timescale 1ns/100ps
// Contract
// RULE1 - Codes above full scale act as full scale; steps ignored there.
// RULE2 - Power-on or brown-out loads each wiper with mid-scale code.
// RULE3 - Shutdown pin low opens both A terminals, ties each wiper to B.
// RULE4 - Serial interface keeps executing commands during pin shutdown.
// RULE5 - Pin shutdown leaves wiper and terminal control contents intact.
// RULE6 - Pin release restores wiper positions and terminal control bits.
// RULE7 - A network's forced-off bit gives that network the pin shutdown state.
// RULE8 - While forced off, the connect bits are ignored but kept.
// RULE9 - Forced-off bits act per network; the pin acts on both together.
// RULE10 - Device is SPI slave only; the host supplies the serial clock.
// RULE11 - Only modes 0,0 and 1,1; clock level at select chooses mode.
// RULE12 - Serial input is latched on each rising clock edge.
// RULE13 - Serial output changes on each falling clock edge.
// RULE14 - Output driven from select; value set by position, command, error.
// RULE15 - Transfers are framed by select and are 8 or 16 bits long.
// RULE16 - Shared pin drives only the error bit and read data bits.
// RULE17 - Shared pin starts driving on the falling edge in the low command bit.
// RULE18 - Shared pin output is open drain with smart pull-up while outputting.
// RULE19 - Shared pin stays output for a read, otherwise returns to input.
// RULE20 - Host keeps clock at 10 MHz, shared-pin reads at 250 kHz.
// RULE21 - Host should release its data line while device drives shared pin.
// RULE22 - A connect bit of 1 connects its terminal, 0 disconnects it.
// RULE23 - Select inactive resets the serial logic and ignores serial lines.
// RULE24 - Step up adds one, step down subtracts one, wipers only.
// RULE25 - Network shutdown is pin asserted OR its forced-off bit.
// RULE26 - Step up at or above full, or down at zero, is ignored.
module dpw_digipot_core #(
   parameter int RES_BITS   = 8,
   parameter bit SINGLE_PIN = 1'b0
) (
   // Clock and reset
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_reset,
   // Serial pins
   input  wire logic                   i_cs_n,
   input  wire logic                   i_sck,
   input  wire logic                   i_sdi,
   output logic                        o_sdo,
   output logic                        o_sdo_oe,
   // Shared data pin
   input  wire logic                   i_shared_data_i,
   output logic                        o_shared_data_o,
   output logic                        o_shared_data_oe,
   output logic                        o_smart_pullup_en,
   // Shutdown pin
   input  wire logic                   i_shutdown_pin_n,
   // Network state
   output dpw_pkg::dpw_wiper_t [1:0]   o_wiper_pos,
   output dpw_pkg::dpw_term_t [1:0]    o_term,
   output logic [7:0]                  o_terminal_control_reg,
   output logic                        o_spi_mode11
);
   import dpw_pkg::*;

   localparam dpw_wiper_t FULL_C = dpw_wiper_t'(1 << RES_BITS);
   localparam dpw_wiper_t MID_C  = FULL_C >> 1;

   dpw_state_t          st_q;
   dpw_state_t          st_d;
   dpw_pins_t           pins_raw;
   dpw_pins_t           pins;
   logic                sck_rise;
   logic                sck_fall;
   logic                serial_on;
   logic                bit_in;
   logic [WIPER_W-1:0]  sh_n;
   logic [3:0]          addr_n;
   dpw_cmd_t            cmd_n;
   logic                err_n;
   logic                is_step;
   logic                step_end;
   logic                frame_end;
   logic                wr_v;
   logic [1:0]          inc_v;
   logic [1:0]          dec_v;
   dpw_wiper_t [1:0]    next_w;
   dpw_wiper_t [1:0]    pos_w;
   logic                sdo_v;
   logic [3:0]          rd_idx;
   logic [1:0]          net_off;

   // Pin capture into the clock domain
   assign pins_raw = {i_cs_n, i_sck, i_sdi, i_shared_data_i, i_shutdown_pin_n};

   dpw_sync3 #(
      .W       ($bits(dpw_pins_t)),
      .RST_VAL (PINS_IDLE)
   ) u_pin_sync (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .i_async   (pins_raw),
      .o_stable  (pins)
   );

   // Clock edges of the host clock, sampled only
   assign serial_on = st_q.cs_act & ~pins.cs_n; // RULE23
   assign sck_rise  = serial_on & pins.sck & ~st_q.sck_prev; // RULE10 RULE12
   assign sck_fall  = serial_on & ~pins.sck & st_q.sck_prev; // RULE13

   // Incoming bit and command fields
   assign bit_in = SINGLE_PIN ? pins.sio : pins.sdi;
   assign sh_n   = {st_q.sh[WIPER_W-2:0], bit_in};
   assign addr_n = sh_n[5:2];
   assign cmd_n  = dpw_cmd_t'(sh_n[1:0]);

   // Unmapped address or step on terminal control is an error
   always_comb begin
      err_n = 1'b1;
      if ((addr_n == ADDR_WIPER0) || (addr_n == ADDR_WIPER1)) begin
         err_n = 1'b0;
      end else if (addr_n == ADDR_TERMINAL_CONTROL_REG) begin
         err_n = (cmd_n == DPW_CMD_INC) || (cmd_n == DPW_CMD_DEC); // RULE24
      end
   end

   // Frame boundaries depend on the command
   assign is_step   = (st_q.cmd == DPW_CMD_INC) || (st_q.cmd == DPW_CMD_DEC);
   assign step_end  = sck_rise && is_step && (st_q.cnt == 5'(CMD_BITS - 1)); // RULE15
   assign frame_end = sck_rise && !is_step && (st_q.cnt == 5'(FRAME16_BITS - 1)); // RULE15
   assign wr_v      = frame_end && (st_q.cmd == DPW_CMD_WRITE) && !st_q.cmd_err;

   // Step requests per wiper, executed regardless of shutdown
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_pot
         assign inc_v[gi] = step_end && !st_q.cmd_err && (st_q.cmd == DPW_CMD_INC)
                            && (st_q.addr == 4'(gi)); // RULE4 RULE24
         assign dec_v[gi] = step_end && !st_q.cmd_err && (st_q.cmd == DPW_CMD_DEC)
                            && (st_q.addr == 4'(gi)); // RULE4 RULE24
         assign net_off[gi] = ~pins.shutdown_pin_n_n | st_q.terminal_control_reg[gi*TC_STRIDE + TC_HW]; // RULE25 RULE9

         dpw_wiper_step #(
            .RES_BITS (RES_BITS)
         ) u_step (
            .i_value (st_q.wiper[gi]),
            .i_inc   (inc_v[gi]),
            .i_dec   (dec_v[gi]),
            .o_next  (next_w[gi]),
            .o_pos   (pos_w[gi])
         );
      end
   endgenerate

   // Output bit for the position about to be shifted out
   assign rd_idx = 4'hF - st_q.cnt[3:0];

   always_comb begin
      if (st_q.cnt < 5'(ERR_BIT_POS)) begin
         sdo_v = 1'b1; // RULE14
      end else if (st_q.cnt == 5'(ERR_BIT_POS)) begin
         sdo_v = ~st_q.cmd_err; // RULE14
      end else if (st_q.is_read && !st_q.cmd_err && (st_q.cnt < 5'(FRAME16_BITS))) begin
         sdo_v = st_q.rdata[rd_idx]; // RULE14
      end else begin
         sdo_v = 1'b1;
      end
   end

   // Next state
   always_comb begin
      st_d          = st_q;
      st_d.sck_prev = pins.sck;
      if (pins.cs_n) begin
         // Idle select clears the serial side except the captured mode and read data
         st_d.cs_act  = 1'b0; // RULE23
         st_d.cnt     = '0; // RULE23
         st_d.sh      = '0; // RULE23
         st_d.addr    = '0; // RULE23
         st_d.cmd     = DPW_CMD_WRITE;
         st_d.cmd_err = 1'b0;
         st_d.is_read = 1'b0;
         st_d.sdo     = 1'b1;
         st_d.sio_drv = 1'b0;
      end else if (!st_q.cs_act) begin
         // Select edge picks the mode and starts driving the separate output (not in the single-pin build)
         st_d.cs_act = 1'b1;
         st_d.mode11 = pins.sck; // RULE11
         st_d.cnt    = '0;
         st_d.sdo    = 1'b1; // RULE14
      end else begin
         if (sck_rise) begin
            st_d.sh  = sh_n; // RULE12
            st_d.cnt = st_q.cnt + 5'h01;
            if (st_q.cnt == 5'(ADDR_CMD_BITS - 1)) begin
               st_d.addr    = addr_n;
               st_d.cmd     = cmd_n;
               st_d.cmd_err = st_q.cmd_err | err_n;
               st_d.is_read = (cmd_n == DPW_CMD_READ);
               unique case (addr_n)
                  ADDR_WIPER0: st_d.rdata = st_q.wiper[0][RDATA_W-1:0];
                  ADDR_WIPER1: st_d.rdata = st_q.wiper[1][RDATA_W-1:0];
                  default:     st_d.rdata = {TERMINAL_CONTROL_REG_RD_D8, st_q.terminal_control_reg};
               endcase
            end
            if (step_end || frame_end) begin
               st_d.cnt     = '0; // RULE15
               st_d.is_read = 1'b0;
            end
         end
         if (sck_fall) begin
            st_d.sdo     = sdo_v; // RULE13
            st_d.sio_drv = (st_q.cnt == 5'(ERR_BIT_POS)) // RULE16 RULE17
                           || ((st_q.cnt > 5'(ERR_BIT_POS)) && st_q.is_read
                               && !st_q.cmd_err); // RULE19
         end
      end
      // Open drain: pull low only, pull-up follows output phase
      st_d.sio_drv = st_d.sio_drv & SINGLE_PIN;
      st_d.sio_oe  = st_d.sio_drv & ~st_d.sdo; // RULE18
      // Wiper registers: steps then writes; shutdown never touches them
      for (int i = 0; i < 2; i++) begin
         st_d.wiper[i] = next_w[i]; // RULE5
         if (wr_v && (st_q.addr == 4'(i))) begin
            st_d.wiper[i] = sh_n; // RULE4
         end
         st_d.pos[i] = pos_w[i]; // RULE1 RULE6
         if (net_off[i]) begin
            // Shutdown: A open, wiper tied to B
            st_d.term[i].a_conn = 1'b0; // RULE3 RULE7
            st_d.term[i].w_conn = 1'b1; // RULE3 RULE7
            st_d.term[i].b_conn = 1'b1; // RULE3 RULE7
            st_d.term[i].w_to_b = 1'b1; // RULE3 RULE7 RULE8
         end else begin
            // Connect bits govern the switches again
            st_d.term[i].a_conn = st_q.terminal_control_reg[i*TC_STRIDE + TC_A]; // RULE22 RULE6 RULE8
            st_d.term[i].w_conn = st_q.terminal_control_reg[i*TC_STRIDE + TC_W]; // RULE22 RULE6 RULE8
            st_d.term[i].b_conn = st_q.terminal_control_reg[i*TC_STRIDE + TC_B]; // RULE22 RULE6 RULE8
            st_d.term[i].w_to_b = 1'b0;
         end
      end
      if (wr_v && (st_q.addr == ADDR_TERMINAL_CONTROL_REG)) begin
         st_d.terminal_control_reg = sh_n[7:0]; // RULE4 RULE5
      end
   end

   // State register; reset stands for power-on or brown-out
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         st_q          <= '0;
         st_q.wiper[0] <= MID_C; // RULE2
         st_q.wiper[1] <= MID_C; // RULE2
         st_q.pos[0]   <= MID_C;
         st_q.pos[1]   <= MID_C;
         st_q.terminal_control_reg     <= TERMINAL_CONTROL_REG_RESET;
         st_q.sdo      <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from state
   assign o_sdo                  = st_q.sdo;
   assign o_sdo_oe               = st_q.cs_act & ~SINGLE_PIN;
   assign o_shared_data_o        = 1'b0;
   assign o_shared_data_oe       = st_q.sio_oe;
   assign o_smart_pullup_en      = st_q.sio_drv;
   assign o_wiper_pos            = st_q.pos;
   assign o_term                 = st_q.term;
   assign o_terminal_control_reg = st_q.terminal_control_reg;
   assign o_spi_mode11           = st_q.mode11;

   // Checks
   a_reset_mid_scale: assert property (@(posedge i_ref_clk) // RULE2
      i_reset |=> (st_q.wiper[0] == MID_C) && (st_q.wiper[1] == MID_C))
      else $error("wiper not mid-scale after reset");

   a_pin_shutdown_both: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE3
      !pins.shutdown_pin_n_n |=> !o_term[0].a_conn && o_term[0].w_to_b
                       && !o_term[1].a_conn && o_term[1].w_to_b)
      else $error("pin shutdown did not reach both networks");

   a_forced_off_net: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE7
      st_q.terminal_control_reg[TC_STRIDE + TC_HW] |=> o_term[1].w_to_b && !o_term[1].a_conn)
      else $error("forced-off bit did not shut network one");

   a_terminal_control_reg_governs: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE8
      (pins.shutdown_pin_n_n && !st_q.terminal_control_reg[TC_HW])
      |=> (o_term[0].a_conn == $past(st_q.terminal_control_reg[TC_A]))
          && (o_term[0].b_conn == $past(st_q.terminal_control_reg[TC_B])) && !o_term[0].w_to_b)
      else $error("connect bits not applied outside shutdown");

   a_idle_cs_reset: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE23
      pins.cs_n |=> (st_q.cnt == '0) && !st_q.cs_act && !o_smart_pullup_en)
      else $error("serial logic not reset while select idle");

   a_mode_capture: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE11
      (pins.cs_n ##1 !pins.cs_n) |=> (o_spi_mode11 == $past(pins.sck)))
      else $error("mode not taken from clock at select");

   a_sdo_fall_only: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE13
      (serial_on && !sck_fall) |=> $stable(o_sdo))
      else $error("serial output changed without falling edge");

   a_inc_ignored_full: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE26
      (inc_v[0] && (st_q.wiper[0] >= FULL_C)) |=> $stable(st_q.wiper[0]))
      else $error("step up at full scale changed wiper");

   a_pos_clamped: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE1
      (o_wiper_pos[0] <= FULL_C) && (o_wiper_pos[1] <= FULL_C))
      else $error("wiper position beyond full scale");

   a_pullup_when_out: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE18
      o_shared_data_oe |-> o_smart_pullup_en && !o_shared_data_o && !st_q.sdo)
      else $error("shared pin drive without pull-up phase");

endmodule : dpw_digipot_core

// ### dpw_spi_host.sv
`timescale 1ns/100ps
module dpw_spi_host #(
   parameter int HALF = 13
) (
   // Reference clock for pacing
   input  wire logic i_ref_clk,
   // Serial lines
   input  wire logic i_sdo,
   output logic      o_cs_n,
   output logic      o_sck,
   output logic      o_sdi
);

   // Idle levels at time zero
   initial begin
      o_cs_n = 1'b1;
      o_sck  = 1'b0;
      o_sdi  = 1'b0;
   end

   // Wait on falling reference edges
   task automatic hold(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask : hold

   // One select frame, MSB first; n may be short to abort
   task automatic xfer(input logic [15:0] tx, input int n, input logic m11,
                       output logic [15:0] rx);
      rx     = '1;
      o_sck  = m11;
      hold(HALF);
      o_cs_n = 1'b0;
      hold(HALF);
      for (int i = 0; i < n; i++) begin
         o_sck = 1'b0;
         o_sdi = tx[15-i];
         hold(HALF);
         rx[15-i] = i_sdo;
         o_sck    = 1'b1;
         hold(HALF);
      end
      if (!m11) begin
         o_sck = 1'b0;
         hold(HALF);
      end
      o_cs_n = 1'b1;
      // Released data line shows no stale level
      o_sdi  = ~o_sdi;
      hold(HALF);
   endtask : xfer

endmodule : dpw_spi_host

// ### dpw_digipot_core_tb.sv
`timescale 1ns/100ps
module dpw_digipot_core_tb;
   import dpw_pkg::*;

   logic                i_ref_clk;
   logic                i_reset;
   logic                cs_n;
   logic                sck;
   logic                sdi;
   logic                sdo;
   logic                sdo_oe;
   logic                shutdown_pin_n_n;
   dpw_wiper_t [1:0]    pos;
   dpw_term_t [1:0]     term;
   logic [7:0]          terminal_control_reg;
   logic                mode11;
   logic [15:0]         rx;
   logic                sp_oe;
   logic                sp_pu;
   logic                shared;
   logic                rd_on = 1'b0;
   logic                pu_seen = 1'b0;
   int                  error_cnt;
   int                  total_checks;

   // Clock generation
   initial i_ref_clk = 1'b0;
   always #2 i_ref_clk = ~i_ref_clk;

   dpw_digipot_core #(.RES_BITS(8), .SINGLE_PIN(1'b0)) i_dut (
      .i_ref_clk              (i_ref_clk),
      .i_reset                (i_reset),
      .i_cs_n                 (cs_n),
      .i_sck                  (sck),
      .i_sdi                  (sdi),
      .o_sdo                  (sdo),
      .o_sdo_oe               (sdo_oe),
      .i_shared_data_i        (1'b1),
      .o_shared_data_o        (),
      .o_shared_data_oe       (),
      .o_smart_pullup_en      (),
      .i_shutdown_pin_n       (shutdown_pin_n_n),
      .o_wiper_pos            (pos),
      .o_term                 (term),
      .o_terminal_control_reg (terminal_control_reg),
      .o_spi_mode11           (mode11)
   );

   // Open-drain shared line: the host level, pulled low by the single-pin copy
   assign shared = sdi & ~sp_oe;

   // Single-pin build on the same host lines
   dpw_digipot_core #(.RES_BITS(8), .SINGLE_PIN(1'b1)) i_dut_sp (
      .i_ref_clk              (i_ref_clk),
      .i_reset                (i_reset),
      .i_cs_n                 (cs_n),
      .i_sck                  (sck),
      .i_sdi                  (1'b0),
      .o_sdo                  (),
      .o_sdo_oe               (),
      .i_shared_data_i        (shared),
      .o_shared_data_o        (),
      .o_shared_data_oe       (sp_oe),
      .o_smart_pullup_en      (sp_pu),
      .i_shutdown_pin_n       (shutdown_pin_n_n),
      .o_wiper_pos            (),
      .o_term                 (),
      .o_terminal_control_reg (),
      .o_spi_mode11           ()
   );

   // Shared line must carry the same read bits as the separate output
   always @(negedge i_ref_clk) begin
      if (rd_on && sp_pu) begin
         pu_seen = 1'b1;
         check("shared pin", 16'(shared), 16'(sdo));
      end
   end

   dpw_spi_host i_host (
      .i_ref_clk (i_ref_clk),
      .i_sdo     (sdo),
      .o_cs_n    (cs_n),
      .o_sck     (sck),
      .o_sdi     (sdi)
   );

   // Verdict and end of run
   task automatic wrap_up;
      if (error_cnt == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up

   // Compare seen against expected
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic chk_pos(input logic [9:0] p0, input logic [9:0] p1);
      check("pos0", 16'(pos[0]), 16'(p0));
      check("pos1", 16'(pos[1]), 16'(p1));
   endtask : chk_pos

   task automatic chk_term(input logic [3:0] t0, input logic [3:0] t1);
      check("term0", 16'(term[0]), 16'(t0));
      check("term1", 16'(term[1]), 16'(t1));
   endtask : chk_term

   // One frame, then mode capture check
   task automatic go(input logic [15:0] tx, input int n, input logic m11);
      i_host.xfer(tx, n, m11, rx);
      check("spi mode", 16'(mode11), 16'(m11));
   endtask : go

   task automatic wr(input logic [3:0] a, input logic [9:0] d, input logic m11);
      go({a, DPW_CMD_WRITE, d}, 16, m11);
      check("write echo", rx, 16'hFFFF);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [8:0] d);
      rd_on   = 1'b1;
      pu_seen = 1'b0;
      go({a, DPW_CMD_READ, 10'h3FF}, 16, 1'b0);
      rd_on = 1'b0;
      check("read data", rx, {7'h7F, d});
      check("shared pull-up", 16'(pu_seen), 16'h0001);
   endtask : rd

   task automatic step(input logic [3:0] a, input dpw_cmd_t c, input logic m11);
      go({a, c, 10'h000}, 8, m11);
      check("step echo", {8'h00, rx[15:8]}, 16'h00FF);
   endtask : step

   // Watchdog against a hung sequence
   initial begin
      repeat (40000) @(posedge i_ref_clk);
      error_cnt++;
      wrap_up();
   end

   // Main sequence
   initial begin
      error_cnt    = 0;
      total_checks = 0;
      shutdown_pin_n_n       = 1'b1;
      i_reset      = 1'b1;
      repeat (4) @(negedge i_ref_clk);
      i_reset = 1'b0;
      repeat (8) @(negedge i_ref_clk);
      chk_pos(10'h080, 10'h080);
      chk_term(4'hE, 4'hE);
      check("terminal_control_reg", 16'(terminal_control_reg), 16'h0077);
      check("sdo oe idle", 16'(sdo_oe), 16'h0000);
      // Code above full scale: clamped, steps ignored
      wr(4'h0, 10'h123, 1'b0);
      step(4'h0, DPW_CMD_INC, 1'b1);
      step(4'h0, DPW_CMD_DEC, 1'b0);
      rd(4'h0, 9'h123);
      chk_pos(10'h100, 10'h080);
      // Step boundaries on the second wiper
      wr(4'h1, 10'h100, 1'b1);
      step(4'h1, DPW_CMD_INC, 1'b0);
      rd(4'h1, 9'h100);
      step(4'h1, DPW_CMD_DEC, 1'b1);
      rd(4'h1, 9'h0FF);
      wr(4'h1, 10'h000, 1'b0);
      step(4'h1, DPW_CMD_DEC, 1'b0);
      rd(4'h1, 9'h000);
      // Two increments back to back in one frame
      go({4'h1, DPW_CMD_INC, 2'b00, 4'h1, DPW_CMD_INC, 2'b00}, 16, 1'b0);
      chk_pos(10'h100, 10'h002);
      // Aborted frame leaves nothing behind
      go({4'h1, DPW_CMD_WRITE, 10'h3FF}, 5, 1'b1);
      step(4'h1, DPW_CMD_INC, 1'b0);
      rd(4'h1, 9'h003);
      // Reserved address and a step on terminal control flag the error bit
      go({4'h2, DPW_CMD_WRITE, 10'h000}, 16, 1'b0);
      check("error echo", rx, 16'hFDFF);
      go({4'h4, DPW_CMD_INC, 10'h000}, 8, 1'b1);
      check("step error", {8'h00, rx[15:8]}, 16'h00FD);
      // Pin shutdown with serial traffic running
      shutdown_pin_n_n = 1'b0;
      repeat (8) @(negedge i_ref_clk);
      chk_term(4'h7, 4'h7);
      wr(4'h0, 10'h040, 1'b0);
      rd(4'h0, 9'h040);
      check("terminal_control_reg kept", 16'(terminal_control_reg), 16'h0077);
      shutdown_pin_n_n = 1'b1;
      repeat (8) @(negedge i_ref_clk);
      chk_pos(10'h040, 10'h003);
      chk_term(4'hE, 4'hE);
      // Forced-off bit per network
      wr(4'h4, 10'h07D, 1'b1);
      chk_term(4'h7, 4'hE);
      rd(4'h4, 9'h17D);
      wr(4'h4, 10'h075, 1'b0);
      chk_term(4'hA, 4'hE);
      shutdown_pin_n_n = 1'b0;
      repeat (8) @(negedge i_ref_clk);
      chk_term(4'h7, 4'h7);
      shutdown_pin_n_n = 1'b1;
      wr(4'h4, 10'h0F5, 1'b0);
      chk_term(4'hA, 4'h7);
      wr(4'h4, 10'h077, 1'b1);
      chk_term(4'hE, 4'hE);
      wrap_up();
   end

endmodule : dpw_digipot_core_tb
